// ==== rtl/psu_defs.svh ====
// constants of the power-save unlock and halt block
//
// Summary of operation
// - command store arms one power save write
// - command register takes byte writes only
// - command register reads and resets undefined
// - any eight-bit code arms the write
// - power save reads need no unlock
// - no interrupt acknowledge after command store
// - interrupt before stop request aborts stop
// - interrupt after stop request wakes stop
// - halt gates only the processor clock
// - halt instruction enters halt mode
// - halt keeps registers and RAM intact
// - NMI, unmasked interrupt or reset end halt
// - wake branches or continues per source, enable
// - lower priority wake in handler stays pending
// - higher priority wake in handler is acknowledged, maskable only if enabled
// - reset pin wake equals ordinary reset
// - stop bit requests stop, self-clears on exit
`ifndef PSU_DEFS_SVH
`define PSU_DEFS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PSU_ADDR_CMD     32'hFFFFF1FC
`define PSU_ADDR_PSC     32'hFFFFF1FE
`define PSU_PSC_RESET    8'h00
`define PSU_CMD_RDVAL    8'h00
`define PSU_PSC_WMASK    8'hF2

// ----------------------------------------------------------------
// power save control fields
// ----------------------------------------------------------------
`define PSU_BIT_NMI2M    7
`define PSU_BIT_NMI1M    6
`define PSU_BIT_NMI0M    5
`define PSU_BIT_INTM     4
`define PSU_BIT_STP      1

// ----------------------------------------------------------------
// access size codes and timing
// ----------------------------------------------------------------
`define PSU_SIZE_BYTE    2'h0
`define PSU_NOP_COUNT    3'h5

`endif

// ==== rtl/psu_pkg.sv ====
// types shared by the power-save unlock and halt block
package psu_pkg;

   typedef enum logic [1:0] {
      PSU_RUN   = 2'b00,
      PSU_COUNT = 2'b01,
      PSU_REQ   = 2'b10,
      PSU_STOP  = 2'b11
   } psu_stop_st_t;

   typedef struct packed {
      logic armed;
      logic boundary;
   } psu_wp_t;

   typedef struct packed {
      logic halted;
      logic wake;
   } psu_halt_t;

   // decides, at a wake, whether the waking request is acknowledged
   function automatic logic psu_wake_takes(
      input logic is_nmi,
      input logic int_enabled,
      input logic in_handler,
      input logic handler_nmi,
      input logic req_higher);
      logic take;
      take = 1'b0;
      if (is_nmi)
         take = !(in_handler && handler_nmi && !req_higher);
      else if (in_handler)
         take = req_higher && int_enabled;
      else
         take = int_enabled;
      return take;
   endfunction : psu_wake_takes

endpackage : psu_pkg

// ==== rtl/psu_wprot.sv ====
// write-protection gate for the power save control register
`timescale 1ns/1ps
`default_nettype none
module psu_wprot
   import psu_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic cmd_wr_byte,
   input  wire logic psc_wr,
   input  wire logic instr_retire,
   output logic      psc_wr_ok,
   output logic      irq_block
);

   psu_wp_t st_ff;
   psu_wp_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (cmd_wr_byte) begin
         nxt_st.armed    = 1'b1;
         nxt_st.boundary = 1'b1;
      end else begin
         if (psc_wr)
            nxt_st.armed = 1'b0;
         if (psc_wr || instr_retire)
            nxt_st.boundary = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   // unarmed writes are silently dropped
   assign psc_wr_ok = psc_wr && st_ff.armed;
   assign irq_block = st_ff.boundary;

endmodule : psu_wprot
`default_nettype wire

// ==== rtl/psu_halt.sv ====
// halt mode holder: gates the processor clock until a wake
`timescale 1ns/1ps
`default_nettype none
module psu_halt
   import psu_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic halt_instr,
   input  wire logic wake_req,
   output logic      halted,
   output logic      wake_pulse
);

   psu_halt_t st_ff;
   psu_halt_t nxt_st;

   always_comb begin
      nxt_st      = st_ff;
      nxt_st.wake = 1'b0;
      if (st_ff.halted && wake_req) begin
         nxt_st.halted = 1'b0;
         nxt_st.wake   = 1'b1;
      end else if (!st_ff.halted && halt_instr) begin
         nxt_st.halted = 1'b1;
      end
   end

   // reset drops halt just like any other reset
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign halted     = st_ff.halted;
   assign wake_pulse = st_ff.wake;

endmodule : psu_halt
`default_nettype wire

// ==== rtl/psu_top.sv ====
// power-save unlock gate, soft stop sequencing and halt control
`timescale 1ns/1ps
`default_nettype none
`include "psu_defs.svh"
module psu_top
   import psu_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   // processor store/load port for the two registers
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   input  wire logic [31:0] bus_addr,
   input  wire logic [1:0]  bus_size,
   input  wire logic [7:0]  bus_wdata,
   output logic      [7:0]  bus_rdata,
   output logic             bus_ack,
   // processor execution status
   input  wire logic        instr_retire,
   input  wire logic        halt_instr,
   input  wire logic        cpu_int_enabled,
   input  wire logic        in_handler,
   input  wire logic        handler_is_nmi,
   input  wire logic        req_is_higher,
   // interrupt requests
   input  wire logic [2:0]  nmi_pin,
   input  wire logic        int_req,
   // power state outputs
   output logic             cpu_clk_en,
   output logic             halted,
   output logic             stop_active,
   output logic             soft_stop_request_out,
   output logic             irq_ack_allow,
   output logic             wake_pulse,
   output logic             wake_ack,
   output logic             wake_resume_next
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0]   nmi_s1;
      logic [2:0]   nmi_s2;
      logic [7:0]   power_save_control;
      logic [3:0]   stop_mask;
      psu_stop_st_t stop_st;
      logic [2:0]   nop_cnt;
      logic         stop_pend;
      logic         stop_wake;
      logic         wake_nmi_src;
      logic [7:0]   rdata;
      logic         ack;
      logic         w_ack;
      logic         w_next;
   } psu_top_t;

   psu_top_t st_ff;
   psu_top_t nxt_st;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   logic hit_cmd;
   logic hit_psc;
   logic cmd_wr_byte;
   logic psc_wr;
   logic psc_wr_ok;
   logic irq_block;
   logic halt_wake_req;
   logic halt_wake;
   logic halted_i;

   assign hit_cmd     = (bus_addr == `PSU_ADDR_CMD);
   assign hit_psc     = (bus_addr == `PSU_ADDR_PSC);
   // wider stores to the command register leave the gate untouched
   assign cmd_wr_byte = bus_wr && hit_cmd
                        && (bus_size == `PSU_SIZE_BYTE);
   assign psc_wr      = bus_wr && hit_psc;

   // ----------------------------------------------------------------
   // sub-blocks
   // ----------------------------------------------------------------
   psu_wprot u_wprot (
      .clock        (clock),
      .rst_b        (rst_b),
      .cmd_wr_byte  (cmd_wr_byte),
      .psc_wr       (psc_wr),
      .instr_retire (instr_retire),
      .psc_wr_ok    (psc_wr_ok),
      .irq_block    (irq_block)
   );

   psu_halt u_halt (
      .clock      (clock),
      .rst_b      (rst_b),
      .halt_instr (halt_instr),
      .wake_req   (halt_wake_req),
      .halted     (halted_i),
      .wake_pulse (halt_wake)
   );

   // ----------------------------------------------------------------
   // wake sources
   // ----------------------------------------------------------------
   logic       any_nmi;
   logic       stop_nmi;
   logic       stop_int;
   logic [2:0] nmi_open;

   // power save masks act only in soft stop; halt ignores them
   assign any_nmi = |st_ff.nmi_s2;
   assign nmi_open = st_ff.nmi_s2 & ~st_ff.stop_mask[3:1];
   assign stop_nmi = |nmi_open;
   assign stop_int = int_req && !st_ff.stop_mask[0];
   assign halt_wake_req = any_nmi || int_req;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st        = st_ff;
      nxt_st.nmi_s1 = nmi_pin;
      nxt_st.nmi_s2 = st_ff.nmi_s1;
      nxt_st.ack    = 1'b0;
      nxt_st.w_ack  = 1'b0;
      nxt_st.w_next = 1'b0;
      nxt_st.stop_wake = 1'b0;

      // register access, one-cycle answer
      if (bus_rd) begin
         nxt_st.ack = 1'b1;
         if (hit_psc)
            nxt_st.rdata = st_ff.power_save_control;
         else
            nxt_st.rdata = `PSU_CMD_RDVAL;
      end else if (bus_wr) begin
         nxt_st.ack = 1'b1;
      end

      // protected write; masks set together with the stop bit
      // take no effect, the previous ones stay in force
      if (psc_wr_ok) begin
         nxt_st.power_save_control = bus_wdata & `PSU_PSC_WMASK;
         if (bus_wdata[`PSU_BIT_STP] && !st_ff.power_save_control[`PSU_BIT_STP])
            nxt_st.stop_mask = {st_ff.power_save_control[`PSU_BIT_NMI2M],
                                st_ff.power_save_control[`PSU_BIT_NMI1M],
                                st_ff.power_save_control[`PSU_BIT_NMI0M],
                                st_ff.power_save_control[`PSU_BIT_INTM]};
         else
            nxt_st.stop_mask = {bus_wdata[`PSU_BIT_NMI2M],
                                bus_wdata[`PSU_BIT_NMI1M],
                                bus_wdata[`PSU_BIT_NMI0M],
                                bus_wdata[`PSU_BIT_INTM]};
      end

      // soft stop sequencer
      unique case (st_ff.stop_st)
         PSU_RUN: begin
            nxt_st.nop_cnt   = 3'h0;
            nxt_st.stop_pend = 1'b0;
            if (psc_wr_ok && bus_wdata[`PSU_BIT_STP])
               nxt_st.stop_st = PSU_COUNT;
         end
         PSU_COUNT: begin
            if (any_nmi || int_req) begin
               // served at once; stop is abandoned
               nxt_st.stop_st = PSU_RUN;
               nxt_st.power_save_control[`PSU_BIT_STP] = 1'b0;
            end else if (instr_retire) begin
               if (st_ff.nop_cnt == `PSU_NOP_COUNT - 3'h1)
                  nxt_st.stop_st = PSU_REQ;
               else
                  nxt_st.nop_cnt = st_ff.nop_cnt + 3'h1;
            end
         end
         PSU_REQ: begin
            // request already out: stop is entered regardless
            nxt_st.stop_st = PSU_STOP;
            if (stop_nmi || stop_int) begin
               nxt_st.stop_pend    = 1'b1;
               nxt_st.wake_nmi_src = stop_nmi;
            end
         end
         PSU_STOP: begin
            if (st_ff.stop_pend || stop_nmi || stop_int) begin
               nxt_st.stop_st = PSU_RUN;
               nxt_st.power_save_control[`PSU_BIT_STP] = 1'b0;
               nxt_st.stop_wake = 1'b1;
               if (!st_ff.stop_pend)
                  nxt_st.wake_nmi_src = stop_nmi;
            end
         end
      endcase

      // halt wake source is captured on the waking cycle
      if (halted_i && halt_wake_req)
         nxt_st.wake_nmi_src = any_nmi;

      // post-wake outcome for either mode
      if (halt_wake || st_ff.stop_wake) begin
         nxt_st.w_ack = psu_wake_takes(st_ff.wake_nmi_src,
                                       cpu_int_enabled,
                                       in_handler,
                                       handler_is_nmi,
                                       req_is_higher);
         nxt_st.w_next = !nxt_st.w_ack;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_ff.nmi_s1       <= 3'h0;
         st_ff.nmi_s2       <= 3'h0;
         st_ff.power_save_control          <= `PSU_PSC_RESET;
         st_ff.stop_mask    <= 4'h0;
         st_ff.stop_st      <= PSU_RUN;
         st_ff.nop_cnt      <= 3'h0;
         st_ff.stop_pend    <= 1'b0;
         st_ff.stop_wake    <= 1'b0;
         st_ff.wake_nmi_src <= 1'b0;
         st_ff.rdata        <= 8'h00;
         st_ff.ack          <= 1'b0;
         st_ff.w_ack        <= 1'b0;
         st_ff.w_next       <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // only the processor clock is gated; state is simply held, so
   // registers and RAM keep their contents across halt
   assign cpu_clk_en  = !halted_i
                        && (st_ff.stop_st != PSU_STOP);
   assign halted      = halted_i;
   assign stop_active = (st_ff.stop_st == PSU_STOP);
   assign soft_stop_request_out = (st_ff.stop_st == PSU_REQ)
                                  || (st_ff.stop_st == PSU_STOP);
   // no acknowledge at the boundary after a command store, nor once
   // the stop request is out; the wake path decides then
   assign irq_ack_allow = !irq_block && !halted_i
                          && !soft_stop_request_out;
   assign bus_rdata        = st_ff.rdata;
   assign bus_ack          = st_ff.ack;
   assign wake_pulse       = halt_wake || st_ff.stop_wake;
   assign wake_ack         = st_ff.w_ack;
   assign wake_resume_next = st_ff.w_next;

endmodule : psu_top
`default_nettype wire

// ==== sim/psu_props.sv ====
// assertion checker for the power-save unlock and halt block
`timescale 1ns/1ps
`default_nettype none
`include "psu_defs.svh"
module psu_props
   import psu_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst_b,
   input wire logic        bus_wr,
   input wire logic        bus_rd,
   input wire logic [31:0] bus_addr,
   input wire logic [1:0]  bus_size,
   input wire logic [7:0]  bus_rdata,
   input wire logic        bus_ack,
   input wire logic        halt_instr,
   input wire logic        int_req,
   input wire logic        cpu_clk_en,
   input wire logic        halted,
   input wire logic        stop_active,
   input wire logic        soft_stop_request_out,
   input wire logic        irq_ack_allow,
   input wire logic        wake_pulse,
   input wire logic        wake_ack,
   input wire logic        wake_resume_next
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   logic cmd_hit;
   assign cmd_hit = bus_addr == `PSU_ADDR_CMD;

   bus_answer_a: assert property ((bus_wr || bus_rd) |=> bus_ack)
      else $error("bus access not answered");
   cmd_blocks_irq_a: assert property (bus_wr && cmd_hit &&
      bus_size == `PSU_SIZE_BYTE |=> !irq_ack_allow)
      else $error("interrupt allowed after command store");
   cmd_read_a: assert property (bus_rd && cmd_hit |=>
      bus_ack && bus_rdata == `PSU_CMD_RDVAL)
      else $error("command register read value wrong");
   halt_enter_a: assert property (halt_instr && !halted &&
      !int_req && !stop_active |=> halted && !cpu_clk_en)
      else $error("halt not entered");
   halt_gate_a: assert property (halted |-> !cpu_clk_en)
      else $error("processor clock runs in halt");
   halt_wake_a: assert property (halted && int_req |=>
      !halted && wake_pulse)
      else $error("halt not left on request");
   wake_outcome_a: assert property (wake_pulse |=>
      wake_ack != wake_resume_next)
      else $error("wake outcome not unique");
   stop_enter_a: assert property (soft_stop_request_out &&
      !stop_active |=> stop_active && !cpu_clk_en)
      else $error("stop not entered after request");

   cover property (halted && int_req);
   cover property (stop_active ##1 wake_pulse);
   cover property (wake_resume_next);
endmodule : psu_props

bind psu_top psu_props u_psu_props (.clock(clock), .rst_b(rst_b),
   .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
   .bus_size(bus_size), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
   .halt_instr(halt_instr), .int_req(int_req), .cpu_clk_en(cpu_clk_en),
   .halted(halted), .stop_active(stop_active),
   .soft_stop_request_out(soft_stop_request_out),
   .irq_ack_allow(irq_ack_allow), .wake_pulse(wake_pulse),
   .wake_ack(wake_ack), .wake_resume_next(wake_resume_next));
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking testbench for the power-save unlock and halt block
`timescale 1ns/1ps
`default_nettype none
`include "psu_defs.svh"
module testbench;
   logic        clock, rst_b, bus_wr, bus_rd, instr_retire, halt_instr;
   logic        cpu_int_enabled, in_handler, handler_is_nmi, req_is_higher;
   logic        int_req, bus_ack, cpu_clk_en, halted, stop_active;
   logic        soft_stop_request_out, irq_ack_allow, wake_pulse;
   logic        wake_ack, wake_resume_next, nmi_w, exp_ack;
   logic [31:0] bus_addr;
   logic [1:0]  bus_size;
   logic [7:0]  bus_wdata, bus_rdata, rd_val;
   logic [2:0]  nmi_pin;
   int          mismatches, checks_done, n;
   localparam logic [31:0] a_cmd = `PSU_ADDR_CMD;
   localparam logic [31:0] a_psc = `PSU_ADDR_PSC;
   logic [7:0]  codes [4] = '{8'hA5, 8'hFF, 8'h3C, 8'h00};
   // nmi, enabled, in handler, handler nmi, higher, acknowledged
   logic [5:0]  hcase [7] = '{6'h11, 6'h00, 6'h18, 6'h1B, 6'h21,
                              6'h29, 6'h2C};

   psu_top u_psu_top (.clock(clock), .rst_b(rst_b), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_size(bus_size),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
      .instr_retire(instr_retire), .halt_instr(halt_instr),
      .cpu_int_enabled(cpu_int_enabled), .in_handler(in_handler),
      .handler_is_nmi(handler_is_nmi), .req_is_higher(req_is_higher),
      .nmi_pin(nmi_pin), .int_req(int_req), .cpu_clk_en(cpu_clk_en),
      .halted(halted), .stop_active(stop_active),
      .soft_stop_request_out(soft_stop_request_out),
      .irq_ack_allow(irq_ack_allow), .wake_pulse(wake_pulse),
      .wake_ack(wake_ack), .wake_resume_next(wake_resume_next));

   always #25 clock = ~clock;

   // ------------------------------------------------------------
   // access and compare tasks
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                        input string what);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic flag(input logic seen, input logic exp, input string what);
      check({7'h00, seen}, {7'h00, exp}, what);
   endtask : flag

   task automatic cyc(input int k);
      repeat (k) @(negedge clock);
   endtask : cyc

   // one strobe cycle, then the answer is looked at in the following cycle
   task automatic access(input logic wr, input logic [31:0] a,
                         input logic [1:0] sz, input logic [7:0] d);
      @(negedge clock);
      bus_wr = wr;
      bus_rd = !wr;
      bus_addr = a;
      bus_size = sz;
      bus_wdata = d;
      @(negedge clock);
      bus_wr = 1'h0;
      bus_rd = 1'h0;
      flag(bus_ack, 1'h1, "bus_ack");
      rd_val = bus_rdata;
   endtask : access

   task automatic wr(input logic [31:0] a, input logic [7:0] d,
                     input logic [1:0] sz = `PSU_SIZE_BYTE);
      access(1'h1, a, sz, d);
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [7:0] exp,
                     input string what);
      access(1'h0, a, `PSU_SIZE_BYTE, 8'h00);
      check(rd_val, exp, what);
   endtask : rd

   task automatic retire(input int k);
      repeat (k) begin
         @(negedge clock);
         instr_retire = 1'h1;
         @(negedge clock);
         instr_retire = 1'h0;
      end
   endtask : retire

   task automatic halt_go;
      @(negedge clock);
      halt_instr = 1'h1;
      @(negedge clock);
      halt_instr = 1'h0;
   endtask : halt_go

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      clock = 1'h0;
      rst_b = 1'h0;
      {bus_wr, bus_rd, instr_retire, halt_instr, int_req} = '0;
      {cpu_int_enabled, in_handler, handler_is_nmi, req_is_higher} = '0;
      {bus_addr, bus_size, bus_wdata, nmi_pin} = '0;
      mismatches = 0;
      checks_done = 0;
      cyc(20);
      rst_b = 1'h1;
      rd(a_psc, `PSU_PSC_RESET, "psc reset");
      rd(a_cmd, `PSU_CMD_RDVAL, "cmd read");
      wr(a_psc, 8'h90);
      rd(a_psc, 8'h00, "psc locked");
      wr(a_cmd, 8'h90, 2'h1);
      wr(a_psc, 8'h90);
      rd(a_psc, 8'h00, "wide cmd store");
      done("reset and refusal");
      foreach (codes[i]) begin
         wr(a_cmd, codes[i]);
         flag(irq_ack_allow, 1'h0, "irq blocked");
         if (i == 1) rd(a_cmd, `PSU_CMD_RDVAL, "cmd read");
         wr(a_psc, codes[i] & 8'hF0);
         rd(a_psc, codes[i] & 8'hF0, "psc unlocked");
         flag(irq_ack_allow, 1'h1, "irq free");
         wr(a_psc, 8'h00);
         rd(a_psc, codes[i] & 8'hF0, "psc relocked");
      end
      done("unlock codes");
      cpu_int_enabled = 1'h1;
      wr(a_cmd, 8'h02);
      wr(a_psc, 8'h02);
      rd(a_psc, 8'h02, "stop bit");
      retire(4);
      cyc(2);
      flag(soft_stop_request_out, 1'h0, "early request");
      retire(1);
      n = 0;
      while (!soft_stop_request_out && n < 4) begin
         cyc(1);
         n++;
      end
      flag(soft_stop_request_out, 1'h1, "stop request");
      int_req = 1'h1;
      cyc(1);
      flag(stop_active, 1'h1, "stop entered");
      cyc(1);
      flag(wake_pulse, 1'h1, "stop wake");
      int_req = 1'h0;
      cyc(1);
      flag(wake_ack, 1'h1, "stop wake ack");
      rd(a_psc, 8'h00, "stop bit cleared");
      wr(a_cmd, 8'h02);
      wr(a_psc, 8'h02);
      retire(2);
      int_req = 1'h1;
      cyc(1);
      int_req = 1'h0;
      cyc(3);
      flag(soft_stop_request_out, 1'h0, "stop aborted");
      rd(a_psc, 8'h00, "abort clears bit");
      done("soft stop");
      foreach (hcase[i]) begin
         {nmi_w, cpu_int_enabled, in_handler, handler_is_nmi,
          req_is_higher, exp_ack} = hcase[i];
         halt_go();
         flag(halted, 1'h1, "halted");
         flag(cpu_clk_en, 1'h0, "clock gated");
         // the no-operation slots after halt retire nothing
         cyc(3);
         flag(halted, 1'h1, "halt holds");
         if (nmi_w) nmi_pin = 3'h1 << (i % 3);
         else int_req = 1'h1;
         n = 0;
         while (!wake_pulse && n < 8) begin
            cyc(1);
            n++;
         end
         flag(halted, 1'h0, "halt left");
         int_req = 1'h0;
         nmi_pin = 3'h0;
         cyc(1);
         flag(wake_ack, exp_ack, "wake ack");
         flag(wake_resume_next, !exp_ack, "wake pending");
         cyc(3);
      end
      done("halt wakes");
      wr(a_cmd, 8'h10);
      wr(a_psc, 8'h10);
      halt_go();
      rst_b = 1'h0;
      cyc(2);
      rst_b = 1'h1;
      flag(halted, 1'h0, "reset wake");
      flag(cpu_clk_en, 1'h1, "clock after reset");
      rd(a_psc, 8'h00, "psc after reset");
      done("reset wake");
      end_sim();
   end

   // the tests need well under a thousand cycles
   initial begin
      cyc(4000);
      mismatches++;
      end_sim();
   end
endmodule : testbench
`default_nettype wire
